// [design/tcm_pkg.sv]
package tcm_pkg;
  // register map, byte addresses
  localparam logic [31:0] TCM_CCR_T0_ADDR  = 32'h4001_4028;
  localparam logic [31:0] TCM_CV_T0_ADDR   = 32'h4001_402c;
  localparam logic [31:0] TCM_EMR_T0_ADDR  = 32'h4001_403c;
  localparam logic [31:0] TCM_CCR_T1_ADDR  = 32'h4001_8028;
  localparam logic [31:0] TCM_CV_T1_ADDR   = 32'h4001_802c;
  localparam logic [31:0] TCM_EMR_T1_ADDR  = 32'h4001_803c;
  localparam logic [31:0] TCM_IRQ_STAT_ADDR = 32'h4001_4070;
  localparam logic [31:0] TCM_IRQ_MASK_ADDR = 32'h4001_4074;

  // capture control fields
  localparam int unsigned TCM_CCR_RISE  = 0;
  localparam int unsigned TCM_CCR_FALL  = 1;
  localparam int unsigned TCM_CCR_IRQEN = 2;
  localparam int unsigned TCM_CCR_W     = 3;

  // external match fields
  localparam int unsigned TCM_EM_W      = 4;
  localparam int unsigned TCM_EMC_LSB   = 4;
  localparam int unsigned TCM_EMC_W     = 8;

  // sizes
  localparam int unsigned TCM_NT        = 2;
  localparam int unsigned TCM_NM        = 4;

  // reset values
  localparam logic [2:0]  TCM_CCR_RST   = 3'h0;
  localparam logic [31:0] TCM_CV_RST    = 32'h0000_0000;
  localparam logic [3:0]  TCM_EM_RST    = 4'h0;
  localparam logic [7:0]  TCM_EMC_RST   = 8'h00;
  localparam logic [1:0]  TCM_IRQ_RST   = 2'h0;
  localparam logic [31:0] TCM_ZERO      = 32'h0000_0000;

  typedef enum logic [1:0] {
    TCM_ACT_NONE   = 2'b00,
    TCM_ACT_CLEAR  = 2'b01,
    TCM_ACT_SET    = 2'b10,
    TCM_ACT_TOGGLE = 2'b11
  } tcm_action_t;
endpackage

// [design/tcm_capture_match.sv]
`timescale 1ns/1ps
module tcm_capture_match
  import tcm_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // counter side, timer 0
  input  wire logic [31:0] timer_count_value_t0,
  input  wire logic [3:0][31:0] match_value_t0,
  input  wire logic [3:0]  pwm_select_t0,
  input  wire logic [3:0]  pwm_level_t0,
  input  wire logic [3:0]  pin_config_match_t0,
  // counter side, timer 1
  input  wire logic [31:0] timer_count_value_t1,
  input  wire logic [3:0][31:0] match_value_t1,
  input  wire logic [3:0]  pwm_select_t1,
  input  wire logic [3:0]  pwm_level_t1,
  input  wire logic [3:0]  pin_config_match_t1,
  // pins
  input  wire logic        capture_input_pin_t0,
  input  wire logic        capture_input_pin_t1,
  output logic      [3:0]  match_pin_out_t0,
  output logic      [3:0]  match_pin_oe_t0,
  output logic      [3:0]  match_pin_out_t1,
  output logic      [3:0]  match_pin_oe_t1,
  // interrupt
  output logic             timer_irq
);

  logic [31:0]             cnt      [TCM_NT];
  logic [3:0][31:0]        mval     [TCM_NT];
  logic [3:0]              pwm_sel  [TCM_NT];
  logic [3:0]              pwm_lvl  [TCM_NT];
  logic [3:0]              pin_cfg  [TCM_NT];
  logic                    cap_pin  [TCM_NT];

  logic [2:0]              ccr_reg  [TCM_NT];
  logic [2:0]              ccr_next [TCM_NT];
  logic [31:0]             cv_reg   [TCM_NT];
  logic [31:0]             cv_next  [TCM_NT];
  logic [3:0]              em_reg   [TCM_NT];
  logic [3:0]              em_next  [TCM_NT];
  logic [7:0]              emc_reg  [TCM_NT];
  logic [7:0]              emc_next [TCM_NT];
  logic [3:0]              eq_reg   [TCM_NT];
  logic [3:0]              eq_next  [TCM_NT];
  logic                    rise_ev  [TCM_NT];
  logic                    fall_ev  [TCM_NT];
  logic [3:0]              out_reg  [TCM_NT];
  logic [3:0]              out_next [TCM_NT];
  logic [3:0]              oe_reg   [TCM_NT];
  logic [3:0]              oe_next  [TCM_NT];
  logic [1:0]              stat_reg;
  logic [1:0]              stat_next;
  logic [1:0]              mask_reg;
  logic [1:0]              mask_next;
  logic                    irq_reg;
  logic                    irq_next;
  logic [31:0]             rd_reg;
  logic [31:0]             rd_next;
  logic                    rdy_reg;
  logic                    rdy_next;
  logic                    err_reg;
  logic                    err_next;

  logic                    wr_acc;
  logic                    hit_any;
  logic [31:0]             rd_val;
  logic [1:0]              cap_ev;
  tcm_action_t             act;

  assign cnt[0]     = timer_count_value_t0;
  assign cnt[1]     = timer_count_value_t1;
  assign mval[0]    = match_value_t0;
  assign mval[1]    = match_value_t1;
  assign pwm_sel[0] = pwm_select_t0;
  assign pwm_sel[1] = pwm_select_t1;
  assign pwm_lvl[0] = pwm_level_t0;
  assign pwm_lvl[1] = pwm_level_t1;
  assign pin_cfg[0] = pin_config_match_t0;
  assign pin_cfg[1] = pin_config_match_t1;
  assign cap_pin[0] = capture_input_pin_t0;
  assign cap_pin[1] = capture_input_pin_t1;

  assign prdata           = rd_reg;
  assign pready           = rdy_reg;
  assign pslverr          = err_reg;
  assign timer_irq        = irq_reg;
  assign match_pin_out_t0 = out_reg[0];
  assign match_pin_oe_t0  = oe_reg[0];
  assign match_pin_out_t1 = out_reg[1];
  assign match_pin_oe_t1  = oe_reg[1];

  // pin synchronisers, one per timer
  for (genvar g = 0; g < TCM_NT; g++) begin : g_sync
    tcm_edge_detect u_edge (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (cap_pin[g]),
      .rise_seen (rise_ev[g]),
      .fall_seen (fall_ev[g])
    );
  end

  // register read mux and address check
  always_comb begin
    rd_val  = TCM_ZERO;
    hit_any = 1'b1;
    unique case (paddr)
      TCM_CCR_T0_ADDR:   rd_val[TCM_CCR_W-1:0] = ccr_reg[0];
      TCM_CCR_T1_ADDR:   rd_val[TCM_CCR_W-1:0] = ccr_reg[1];
      TCM_CV_T0_ADDR:    rd_val = cv_reg[0];
      TCM_CV_T1_ADDR:    rd_val = cv_reg[1];
      TCM_EMR_T0_ADDR:   rd_val[TCM_EMC_LSB+TCM_EMC_W-1:0] =
                           {emc_reg[0], em_reg[0]};
      TCM_EMR_T1_ADDR:   rd_val[TCM_EMC_LSB+TCM_EMC_W-1:0] =
                           {emc_reg[1], em_reg[1]};
      TCM_IRQ_STAT_ADDR: rd_val[1:0] = stat_reg;
      TCM_IRQ_MASK_ADDR: rd_val[1:0] = mask_reg;
      default:           hit_any = 1'b0;
    endcase
  end

  // apb handshake: one wait-free access phase
  always_comb begin
    rdy_next = psel & ~penable;
    rd_next  = rd_reg;
    err_next = 1'b0;
    if (psel && !penable) begin
      rd_next  = pwrite ? TCM_ZERO : rd_val;
      err_next = ~hit_any;
    end
    wr_acc = psel & penable & rdy_reg & pwrite & ~err_reg;
  end

  // capture, match and pin logic per timer
  always_comb begin
    for (int t = 0; t < TCM_NT; t++) begin
      ccr_next[t] = ccr_reg[t];
      emc_next[t] = emc_reg[t];
      em_next[t]  = em_reg[t];
      cv_next[t]  = cv_reg[t];
      // edge from synchronised successive samples
      cap_ev[t] = (rise_ev[t] & ccr_reg[t][TCM_CCR_RISE])
                | (fall_ev[t] & ccr_reg[t][TCM_CCR_FALL]);
      if (cap_ev[t]) begin
        cv_next[t] = cnt[t];
      end
      for (int m = 0; m < TCM_NM; m++) begin
        eq_next[t][m] = (cnt[t] == mval[t][m]);
      end
    end
    if (wr_acc) begin
      unique case (paddr)
        TCM_CCR_T0_ADDR: ccr_next[0] = pwdata[TCM_CCR_W-1:0];
        TCM_CCR_T1_ADDR: ccr_next[1] = pwdata[TCM_CCR_W-1:0];
        TCM_EMR_T0_ADDR: begin
          em_next[0]  = pwdata[TCM_EM_W-1:0];
          emc_next[0] = pwdata[TCM_EMC_LSB+TCM_EMC_W-1:TCM_EMC_LSB];
        end
        TCM_EMR_T1_ADDR: begin
          em_next[1]  = pwdata[TCM_EM_W-1:0];
          emc_next[1] = pwdata[TCM_EMC_LSB+TCM_EMC_W-1:TCM_EMC_LSB];
        end
        default: ;
      endcase
    end
    for (int t = 0; t < TCM_NT; t++) begin
      for (int m = 0; m < TCM_NM; m++) begin
        act = tcm_action_t'(emc_next[t][2*m +: 2]);
        // match event is the first cycle of equality
        if (eq_next[t][m] && !eq_reg[t][m] && !pwm_sel[t][m]) begin
          unique case (act)
            TCM_ACT_NONE:   em_next[t][m] = em_next[t][m];
            TCM_ACT_CLEAR:  em_next[t][m] = 1'b0;
            TCM_ACT_SET:    em_next[t][m] = 1'b1;
            TCM_ACT_TOGGLE: em_next[t][m] = ~em_next[t][m];
          endcase
        end
        out_next[t][m] = pwm_sel[t][m] ? pwm_lvl[t][m]
                                       : em_next[t][m];
      end
      oe_next[t] = pin_cfg[t];
    end
  end

  // sticky capture flags, write one to clear, set wins
  always_comb begin
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (wr_acc && paddr == TCM_IRQ_MASK_ADDR) begin
      mask_next = pwdata[1:0];
    end
    if (wr_acc && paddr == TCM_IRQ_STAT_ADDR) begin
      stat_next = stat_reg & ~pwdata[1:0];
    end
    for (int t = 0; t < TCM_NT; t++) begin
      if (cap_ev[t] && ccr_reg[t][TCM_CCR_IRQEN]) begin
        stat_next[t] = 1'b1;
      end
    end
    irq_next = |(stat_reg & mask_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < TCM_NT; t++) begin
        ccr_reg[t] <= TCM_CCR_RST;
        cv_reg[t]  <= TCM_CV_RST;
        em_reg[t]  <= TCM_EM_RST;
        emc_reg[t] <= TCM_EMC_RST;
        eq_reg[t]  <= TCM_EM_RST;
        out_reg[t] <= TCM_EM_RST;
        oe_reg[t]  <= TCM_EM_RST;
      end
      stat_reg <= TCM_IRQ_RST;
      mask_reg <= TCM_IRQ_RST;
      irq_reg  <= 1'b0;
      rd_reg   <= TCM_ZERO;
      rdy_reg  <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      for (int t = 0; t < TCM_NT; t++) begin
        ccr_reg[t] <= ccr_next[t];
        cv_reg[t]  <= cv_next[t];
        em_reg[t]  <= em_next[t];
        emc_reg[t] <= emc_next[t];
        eq_reg[t]  <= eq_next[t];
        out_reg[t] <= out_next[t];
        oe_reg[t]  <= oe_next[t];
      end
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
      rd_reg   <= rd_next;
      rdy_reg  <= rdy_next;
      err_reg  <= err_next;
    end
  end

endmodule // tcm_capture_match

// capture pin synchroniser and edge detector
module tcm_edge_detect
  import tcm_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // asynchronous pin
  input  wire logic pin_async,
  // edges seen after synchronisation
  output logic      rise_seen,
  output logic      fall_seen
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // two flops against metastability, the third keeps the previous sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // one pulse per edge, from successive synchronised samples
  assign rise_seen = s2_reg & ~s3_reg;
  assign fall_seen = ~s2_reg & s3_reg;

endmodule // tcm_edge_detect

// [verification/tcm_capture_match_assertions.sv]
`timescale 1ns/1ps
module tcm_checker
  import tcm_pkg::*;
(
  // apb
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic             pready,
  input wire logic             pslverr,
  // counter side
  input wire logic [31:0]      timer_count_value_t0,
  input wire logic [3:0][31:0] match_value_t0,
  input wire logic [3:0]       pwm_select_t0,
  input wire logic [3:0]       pwm_level_t0,
  input wire logic [3:0]       pin_config_match_t1,
  // pins and interrupt
  input wire logic             capture_input_pin_t0,
  input wire logic             capture_input_pin_t1,
  input wire logic [3:0]       match_pin_out_t0,
  input wire logic [3:0]       match_pin_oe_t1,
  input wire logic             timer_irq
);
  logic [1:0] pin_q;
  logic [2:0] chg;
  logic [1:0] pins;
  assign pins = {capture_input_pin_t1, capture_input_pin_t0};
  // history of capture pin changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 2'h0;
      chg   <= 3'h0;
    end else begin
      pin_q <= pins;
      chg   <= {chg[1:0], |(pin_q ^ pins)};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_oe; 1'b1 |=> match_pin_oe_t1 == $past(pin_config_match_t1);
  endproperty
  property p_pwm;
    pwm_select_t0[0] |=> match_pin_out_t0[0] == $past(pwm_level_t0[0]);
  endproperty
  property p_hold;
    $changed(match_pin_out_t0[0]) |-> $past(pwm_select_t0[0])
      || $past(pwm_select_t0[0], 2) || $past(psel && penable)
      || $past(timer_count_value_t0 == match_value_t0[0]);
  endproperty
  property p_irq_hold;
    $fell(timer_irq) |-> $past(psel && penable && pwrite, 2);
  endproperty
  property p_irq_rise;
    $rose(timer_irq) |-> $past(psel && penable && pwrite, 2) || $past(chg[2]);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_pwm: assert property (p_pwm) else $error("pwm level lost");
  a_hold: assert property (p_hold) else $error("match pin moved");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  a_irq_rise: assert property (p_irq_rise) else $error("irq raised");
endmodule // tcm_checker
bind tcm_capture_match tcm_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .pslverr, .timer_count_value_t0, .match_value_t0,
  .pwm_select_t0, .pwm_level_t0, .pin_config_match_t1,
  .capture_input_pin_t0, .capture_input_pin_t1, .match_pin_out_t0,
  .match_pin_oe_t1, .timer_irq);

// [verification/tcm_pin_model.sv]
`timescale 1ns/1ps
module tcm_pin_model (
  // control
  input wire logic       pclk,
  input wire logic [1:0] level_req,
  // capture pins
  output logic           cap_t0,
  output logic           cap_t1
);
  initial {cap_t1, cap_t0} = 2'h0;
  // levels change only just after an edge and last whole cycles
  always @(posedge pclk) {cap_t1, cap_t0} <= level_req;
endmodule // tcm_pin_model

// [verification/tcm_tb_top.sv]
`timescale 1ns/1ps
module timer_capture_and_match_outputs_tb_top;
  import tcm_pkg::*;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel, penable, pwrite, pready, pslverr, cp0, cp1, irq;
  logic             er, msk;
  logic [31:0]      paddr, pwdata, prdata, rd;
  logic [31:0]      tc [2];
  logic [31:0]      exp_cv [2];
  logic [3:0][31:0] mv [2];
  logic [3:0]       psl [2], plv [2], pcf [2], po [2], poe [2];
  logic [1:0]       lvl;
  integer           seed, n_fail, samples_checked, cyc;
  logic [31:0]      ra [8] = '{TCM_CCR_T0_ADDR, TCM_CV_T0_ADDR,
    TCM_EMR_T0_ADDR, TCM_CCR_T1_ADDR, TCM_CV_T1_ADDR, TCM_EMR_T1_ADDR,
    TCM_IRQ_STAT_ADDR, TCM_IRQ_MASK_ADDR};
  always #5 pclk = ~pclk;
  tcm_capture_match DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_count_value_t0(tc[0]), .match_value_t0(mv[0]),
    .pwm_select_t0(psl[0]), .pwm_level_t0(plv[0]),
    .pin_config_match_t0(pcf[0]), .timer_count_value_t1(tc[1]),
    .match_value_t1(mv[1]), .pwm_select_t1(psl[1]), .pwm_level_t1(plv[1]),
    .pin_config_match_t1(pcf[1]), .capture_input_pin_t0(cp0),
    .capture_input_pin_t1(cp1), .match_pin_out_t0(po[0]),
    .match_pin_oe_t0(poe[0]), .match_pin_out_t1(po[1]),
    .match_pin_oe_t1(poe[1]), .timer_irq(irq));
  tcm_pin_model PINS (.pclk(pclk), .level_req(lvl), .cap_t0(cp0),
    .cap_t1(cp1));
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude;
    end
  end
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic em_f(input logic b, input logic [1:0] a);
    case (a)
      2'h0: return b;
      2'h1: return 1'b0;
      2'h2: return 1'b1;
      default: return ~b;
    endcase
  endfunction
  task automatic cap(input int t, input logic l, en, ie);
    logic [31:0] c;
    c = $random(seed);
    msk = 1'($random(seed));
    apb(1'b1, TCM_IRQ_MASK_ADDR, {30'h0, msk, msk});
    tc[t] <= c;
    lvl[t] <= l;
    repeat (6) @(posedge pclk);
    if (en) exp_cv[t] = c;
    apb(1'b0, TCM_CV_T0_ADDR + 32'(t) * 32'h4000, 32'h0);
    chk("capture_value", rd, exp_cv[t]);
    chk("timer_irq", 32'(irq), 32'(en & ie & msk));
    apb(1'b1, TCM_IRQ_MASK_ADDR, 32'h3);
    repeat (2) @(posedge pclk);
    chk("irq_held", 32'(irq), 32'(en & ie));
    apb(1'b1, TCM_IRQ_STAT_ADDR, 32'h1 << t);
    repeat (2) @(posedge pclk);
    chk("irq_cleared", 32'(irq), 32'h0);
  endtask
  task automatic mat(input int t, m, input logic [1:0] a);
    logic [3:0]  e;
    logic [31:0] v;
    e = 4'($random(seed));
    v = $random(seed);
    apb(1'b1, TCM_EMR_T0_ADDR + 32'(t) * 32'h4000, {20'h0, {4{a}}, e});
    mv[t][m] <= v;
    @(posedge pclk);
    tc[t] <= v;
    @(posedge pclk);
    tc[t] <= v + 32'h1;
    if (psl[t][m] == 1'b0) e[m] = em_f(e[m], a);
    repeat (3) @(posedge pclk);
    apb(1'b0, TCM_EMR_T0_ADDR + 32'(t) * 32'h4000, 32'h0);
    chk("external_match", rd, {20'h0, {4{a}}, e});
    chk("match_pin", 32'(po[t]), 32'((e & ~psl[t]) | (plv[t] & psl[t])));
    chk("match_oe", 32'(poe[t]), 32'(pcf[t]));
  endtask
  initial begin
    seed = 76221;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    {psel, penable, pwrite, paddr, pwdata, lvl, msk} = '0;
    for (int t = 0; t < 2; t++) begin
      {tc[t], mv[t], psl[t], plv[t], pcf[t], exp_cv[t]} = '0;
    end
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset_value", rd, 32'h0);
    end
    apb(1'b1, TCM_CV_T0_ADDR, 32'hffff_ffff);
    apb(1'b0, TCM_CV_T0_ADDR, 32'h0);
    chk("cv_read_only", rd, 32'h0);
    apb(1'b0, 32'h4001_4080, 32'h0);
    chk("unmapped_err", 32'(er), 32'h1);
    for (int t = 0; t < 2; t++) begin
      for (int k = 0; k < 8; k++) begin
        apb(1'b1, TCM_CCR_T0_ADDR + 32'(t) * 32'h4000, 32'(k));
        apb(1'b0, TCM_CCR_T0_ADDR + 32'(t) * 32'h4000, 32'h0);
        chk("capture_control", rd, 32'(k));
        cap(t, 1'b1, k[0], k[2]);
        cap(t, 1'b0, k[1], k[2]);
      end
      for (int a = 0; a < 4; a++) begin
        psl[t] <= 4'($random(seed));
        plv[t] <= 4'($random(seed));
        pcf[t] <= 4'($random(seed));
        for (int m = 0; m < 4; m++) mat(t, m, 2'(a));
      end
    end
    conclude;
  end
endmodule // timer_capture_and_match_outputs_tb_top
